/* File: design/move_return_defines.svh */
// reset values, field positions and cycle counts for the move/return slice
// assumes inclusion by bare name from design files only
`ifndef MOVE_RETURN_DEFINES_SVH
`define MOVE_RETURN_DEFINES_SVH

`define ACC_RESET          8'h00
`define PC_RESET           13'h0000
`define GIE_RESET          1'b0
`define GIE_BIT            7
`define FILE_ADDR_MAX      7'h7f
`define LITERAL_MAX        8'hff
`define SINGLE_CYCLES      1
`define RETURN_CYCLES      2
`define STACK_DEPTH        8
`define PC_WIDTH           13

`endif

/* File: design/move_return_pkg.sv */
// types shared by the move/return execution slice
// widths of fixed fields are written out here, not taken from the defines header
package move_return_pkg;

	typedef enum logic [2:0] {
		idle_op                 = 3'h0,
		store_accumulator_op    = 3'h1,
		load_literal_op         = 3'h2,
		interrupt_return_op     = 3'h3,
		literal_return_op       = 3'h4,
		subroutine_return_op    = 3'h5
	} op_type;

	typedef enum logic [1:0] {
		exec_state   = 2'h0,
		second_state = 2'h1
	} state_type;

	typedef struct packed {
		logic         valid;
		op_type       op;
		logic [6:0]   file_addr;
		logic [7:0]   literal;
	} issue_type;

	typedef struct packed {
		logic         valid;
		logic [6:0]   addr;
		logic [7:0]   data;
	} file_write_type;

endpackage

/* File: design/return_stack.sv */
// circular hardware return stack, flip-flop storage indexed by a pointer
// assumes one clock; push and pop never requested together by the core
`timescale 1ns/10ps
`include "move_return_defines.svh"
module return_stack #(
	parameter int WIDTH = `PC_WIDTH,
	parameter int DEPTH = `STACK_DEPTH
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             push,
	input  wire logic [WIDTH-1:0] push_data,
	input  wire logic             pop,
	output logic [WIDTH-1:0]      stack_top,
	output logic                  empty,
	output logic                  full
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] entry_reg [DEPTH];
	logic [PW-1:0]    ptr_reg;
	logic [PW:0]      count_reg;
	logic [PW-1:0]    top_index;

	assign top_index = ptr_reg - 1'b1;
	assign stack_top = entry_reg[top_index];
	assign empty     = (count_reg == '0);
	assign full      = (count_reg == (PW+1)'(DEPTH));

	// overflow wraps and overwrites the oldest entry, like a ring
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ptr_reg <= '0;
		end else if (push) begin
			ptr_reg <= ptr_reg + 1'b1;
		end else if (pop) begin
			ptr_reg <= ptr_reg - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count_reg <= '0;
		end else if (push && !full) begin
			count_reg <= count_reg + 1'b1;
		end else if (pop && !empty) begin
			count_reg <= count_reg - 1'b1;
		end
	end

	genvar i;
	generate
		for (i = 0; i < DEPTH; i++) begin : g_entry
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					entry_reg[i] <= '0;
				end else if (push && ptr_reg == PW'(i)) begin
					entry_reg[i] <= push_data;
				end
			end
		end
	endgenerate
endmodule

/* File: design/move_and_return_instr_exec.sv */
// execution of accumulator moves, literal load, idle and the three returns
// assumes decoded instructions from the fetch stage on the same clock;
// pushes (calls, interrupt entry) come from logic outside this slice
//
// What this block does
// - accumulator to 7-bit addressed file register, one cycle, flags kept
// - load 8-bit literal into accumulator in one cycle, flags kept
// - interrupt return pops stack top into pc, two cycles, flags kept
// - interrupt return sets global enable, bit 7 of interrupt control
// - literal return puts literal in accumulator, two cycles, flags kept
// - literal return pops stack and reloads program counter from top entry
// - subroutine return pops stack top into pc, two cycles, flags kept
`timescale 1ns/10ps
`include "move_return_defines.svh"
module move_and_return_instr_exec #(
	parameter int PC_WIDTH    = `PC_WIDTH,
	parameter int STACK_DEPTH = `STACK_DEPTH
) (
	input  wire logic                        clk,
	input  wire logic                        reset_n,
	input  wire move_return_pkg::issue_type  issue,
	output logic                             issue_ready,
	input  wire logic                        push_valid,
	input  wire logic [PC_WIDTH-1:0]         push_addr,
	output logic                             push_ready,
	input  wire logic                        gie_clear,
	output logic [7:0]                       accumulator,
	output move_return_pkg::file_write_type  file_write,
	output logic [PC_WIDTH-1:0]              program_counter,
	output logic                             global_int_enable,
	output logic [7:0]                       interrupt_control_image,
	output logic                             flags_write,
	output logic                             retired,
	output logic                             stack_empty,
	output logic                             stack_full
);
	import move_return_pkg::*;

	state_type             state_reg;
	state_type             state_next;
	logic [7:0]            acc_reg;
	logic [PC_WIDTH-1:0]   pc_reg;
	logic                  gie_reg;
	file_write_type        fw_reg;
	logic                  retired_reg;
	logic                  take;
	logic                  is_return;
	logic                  do_pop;
	logic                  do_push;
	logic [PC_WIDTH-1:0]   stack_top;
	logic                  is_store;
	logic                  is_load;
	logic                  is_int_return;
	logic                  is_lit_return;
	logic                  is_sub_return;

	// the second cycle of a return is a dead slot: the fetched word after
	// the return is stale, so nothing is taken in the cycle after the pc is reloaded
	assign issue_ready = (state_reg == exec_state);
	assign take        = issue.valid && issue_ready;

	// one flag per decoded op; unused codes leave all low and act as idle
	always_comb begin
		is_store      = 1'b0;
		is_load       = 1'b0;
		is_int_return = 1'b0;
		is_lit_return = 1'b0;
		is_sub_return = 1'b0;
		case (issue.op)
			store_accumulator_op: begin
				is_store = 1'b1;
			end
			load_literal_op: begin
				is_load = 1'b1;
			end
			interrupt_return_op: begin
				is_int_return = 1'b1;
			end
			literal_return_op: begin
				is_lit_return = 1'b1;
			end
			subroutine_return_op: begin
				is_sub_return = 1'b1;
			end
			idle_op: begin
				is_store = 1'b0;
			end
			default: begin
				is_store = 1'b0;
			end
		endcase
	end

	assign is_return = is_int_return || is_lit_return || is_sub_return;

	assign do_pop = take && is_return;

	// a push never shares a cycle with a pop, so the stack stays coherent
	assign push_ready = !do_pop;
	assign do_push    = push_valid && push_ready;

	// pop on an empty stack yields a stale entry; callers must pair returns
	return_stack #(
		.WIDTH (PC_WIDTH),
		.DEPTH (STACK_DEPTH)
	) u_stack (
		.clk       (clk),
		.reset_n   (reset_n),
		.push      (do_push),
		.push_data (push_addr),
		.pop       (do_pop),
		.stack_top (stack_top),
		.empty     (stack_empty),
		.full      (stack_full)
	);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			exec_state: begin
				if (do_pop) begin
					state_next = second_state;
				end
			end
			second_state: begin
				state_next = exec_state;
			end
			default: begin
				state_next = exec_state;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= exec_state;
		end else begin
			state_reg <= state_next;
		end
	end

	// accumulator changes only for literal load and literal return
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			acc_reg <= `ACC_RESET;
		end else if (take) begin
			case (issue.op)
				load_literal_op: begin
					acc_reg <= issue.literal;
				end
				literal_return_op: begin
					acc_reg <= issue.literal;
				end
				default: begin
					acc_reg <= acc_reg;
				end
			endcase
		end
	end

	// returns reload from the stack top, everything else steps by one
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pc_reg <= `PC_RESET;
		end else if (do_pop) begin
			pc_reg <= stack_top;
		end else if (take) begin
			pc_reg <= pc_reg + 1'b1;
		end
	end

	// set from an interrupt return beats a clear in the same cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			gie_reg <= `GIE_RESET;
		end else if (take && is_int_return) begin
			gie_reg <= 1'b1;
		end else if (gie_clear) begin
			gie_reg <= 1'b0;
		end
	end

	// one-cycle write strobe toward the file register array
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fw_reg <= '0;
		end else if (take && is_store) begin
			fw_reg.valid <= 1'b1;
			fw_reg.addr  <= issue.file_addr;
			fw_reg.data  <= acc_reg;
		end else begin
			fw_reg.valid <= 1'b0;
		end
	end

	// retire pulses in the cycle after the last cycle of each instruction
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			retired_reg <= 1'b0;
		end else begin
			retired_reg <= (take && !is_return)
				|| (state_reg == second_state);
		end
	end

	always_comb begin
		interrupt_control_image           = 8'h00;
		interrupt_control_image[`GIE_BIT] = gie_reg;
	end

	// none of these instructions touch the status flags
	assign flags_write       = 1'b0;
	assign accumulator       = acc_reg;
	assign file_write        = fw_reg;
	assign program_counter   = pc_reg;
	assign global_int_enable = gie_reg;
	assign retired           = retired_reg;
endmodule

/* File: testbench/exec_checker.sv */
// port assertions for the move/return execution block
// assumes a bind onto that block; one clock, async low reset
`timescale 1ns/10ps
module exec_checker #(
	parameter int PC_WIDTH = 13
) (
	input wire logic                           clk,
	input wire logic                           reset_n,
	input wire move_return_pkg::issue_type     issue,
	input wire logic                           issue_ready,
	input wire logic [7:0]                     accumulator,
	input wire move_return_pkg::file_write_type file_write,
	input wire logic [PC_WIDTH-1:0]            program_counter,
	input wire logic                           global_int_enable,
	input wire logic [7:0]                     interrupt_control_image,
	input wire logic                           flags_write,
	input wire logic                           retired
);
	import move_return_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire tk = issue.valid && issue_ready;
	wire rt = issue.op inside {interrupt_return_op, literal_return_op,
		subroutine_return_op};
	store_write_a: assert property (
		tk && issue.op == store_accumulator_op
		|=> file_write == {1'b1, $past(issue.file_addr), $past(accumulator)})
		else $error("bad store");
	literal_acc_a: assert property (
		tk && issue.op inside {load_literal_op, literal_return_op}
		|=> accumulator == $past(issue.literal)) else $error("bad literal");
	gie_set_a: assert property (
		tk && issue.op == interrupt_return_op
		|=> global_int_enable) else $error("enable not set");
	gie_image_a: assert property (
		interrupt_control_image == {global_int_enable, 7'h00})
		else $error("bad image");
	return_two_a: assert property (tk && rt
		|=> !retired && !issue_ready ##1 retired) else $error("bad return");
	return_hold_a: assert property (tk && rt
		|=> ##1 $stable(program_counter)) else $error("dead slot moved");
	single_retire_a: assert property (
		tk && !rt |=> retired) else $error("not one cycle");
	idle_keep_a: assert property (tk && issue.op == idle_op
		|=> $stable(accumulator) && !file_write.valid
		&& PC_WIDTH'(program_counter - $past(program_counter)) == 1)
		else $error("idle changed state");
	flags_kept_a: assert property (
		!flags_write) else $error("flags written");
endmodule

/* File: testbench/tb.sv */
// self-checking bench for the move/return execution block
// assumes package, defines header and checker compiled first
`timescale 1ns/10ps
module tb;
	import move_return_pkg::*;
	logic           clk = 0;
	logic           reset_n = 0;
	issue_type      issue = '0;
	logic           push_valid = 0;
	logic [12:0]    push_addr = '0;
	logic           gie_clear = 0;
	wire            issue_ready, push_ready, global_int_enable;
	wire            flags_write, retired, stack_empty, stack_full;
	wire [7:0]      accumulator, interrupt_control_image;
	wire [12:0]     program_counter;
	file_write_type file_write;
	int             error_cnt = 0;
	int             n_checks = 0;
	logic [12:0]    exp_pc = '0;
	move_and_return_instr_exec u_move_and_return_instr_exec (
		.clk, .reset_n, .issue, .issue_ready, .push_valid, .push_addr,
		.push_ready, .gie_clear, .accumulator, .file_write,
		.program_counter, .global_int_enable, .interrupt_control_image,
		.flags_write, .retired, .stack_empty, .stack_full);
	always #5 clk = ~clk;
	task automatic chk(input string nm, input logic [15:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic iss(input op_type op, input logic [6:0] a,
		input logic [7:0] k);
		@(negedge clk);
		issue = {1'b1, op, a, k};
		@(negedge clk);
		issue.valid = 0;
		exp_pc++;
	endtask
	task automatic t_moves;
		iss(load_literal_op, 7'h00, 8'hff);
		chk("acc", accumulator, 8'hff);
		iss(store_accumulator_op, 7'h7f, 8'h00);
		chk("fw", file_write, {1'b1, 7'h7f, 8'hff});
		chk("pc", program_counter, exp_pc);
		@(negedge clk);
		chk("fw one", file_write.valid, 0);
		issue = {1'b1, load_literal_op, 7'h00, 8'h5a};
		@(negedge clk);
		issue = {1'b1, store_accumulator_op, 7'h00, 8'h00};
		@(negedge clk);
		issue.valid = 0;
		exp_pc += 2;
		chk("fw b2b", file_write, {1'b1, 7'h00, 8'h5a});
		iss(idle_op, 7'h55, 8'h33);
		chk("idle acc", accumulator, 8'h5a);
		chk("idle fw", file_write.valid, 0);
		chk("idle pc", program_counter, exp_pc);
	endtask
	// a held issue in the dead slot must be refused, pc stays put
	task automatic t_ret(input op_type op, input logic [12:0] x);
		@(negedge clk);
		push_valid = 1;
		push_addr = x;
		gie_clear = 1;
		@(negedge clk);
		push_valid = 0;
		issue = {1'b1, op, 7'h00, 8'ha5};
		#1 chk("push rdy", push_ready, 0);
		@(negedge clk);
		gie_clear = 0;
		issue.op = idle_op;
		chk("pc", program_counter, x);
		// clear was held through the return's edge: the set must win
		chk("gie", global_int_enable,
			op == interrupt_return_op);
		chk("acc", accumulator,
			op == literal_return_op ? 8'ha5 : 8'h5a);
		chk("ready", issue_ready, 0);
		@(negedge clk);
		chk("pc hold", program_counter, x);
		chk("retired", retired, 1);
		chk("empty", stack_empty, 1);
		@(negedge clk);
		issue.valid = 0;
		chk("pc next", program_counter, 13'(x + 13'h1));
	endtask
	// full must rise on the eighth push, not the seventh
	task automatic t_full;
		@(negedge clk);
		push_valid = 1;
		push_addr = 13'h0123;
		repeat (7) @(negedge clk);
		chk("not full", stack_full, 0);
		chk("not empty", stack_empty, 0);
		@(negedge clk);
		push_valid = 0;
		chk("full", stack_full, 1);
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(negedge clk);
		chk("rst pc", program_counter, 0);
		chk("rst empty", stack_empty, 1);
		reset_n = 1;
		t_moves;
		t_ret(interrupt_return_op, 13'h1fff);
		t_ret(subroutine_return_op, 13'h0abc);
		t_ret(literal_return_op, 13'h0001);
		t_full;
		conclude;
	end
	// run needs under 100 cycles; allow twenty times that
	initial begin
		#20000;
		error_cnt++;
		conclude;
	end
endmodule
bind move_and_return_instr_exec exec_checker #(.PC_WIDTH(PC_WIDTH)) u_chk (
	.clk, .reset_n, .issue, .issue_ready, .accumulator, .file_write,
	.program_counter, .global_int_enable, .interrupt_control_image,
	.flags_write, .retired);
